// ==== hw/mcss_top.sv ====
// Main clock source control: registers, stabilization counter, halt.
// Assumes an AXI4-Lite master on sys_clk and a crystal clock pin below 25 MHz.
//
// Function
// [RQ1] Reset always starts on internal oscillator
// [RQ2] Crystal setup: mode, wait, stop, poll, select
// [RQ3] Enable pin bit; gain above 10 MHz
// [RQ4] Mode register: one 8-bit write only
// [RQ5] Three-bit stop-release wait select field
// [RQ6] Clear crystal stop starts it; internal stop bit
// [RQ7] Eight progressive elapsed-count flags for polling
// [RQ8] Polled wait not above selected wait
// [RQ9] Select bit: high-speed or internal oscillator
// [RQ10] Return: restart internal, wait, clear select
// [RQ11] Already-done setup steps may be skipped
// [RQ12] Halt instruction halts on either source
// [RQ13] External input needs no stabilization polling
// [RQ14] Old clock runs two cycles before switching
// [RQ15] State bit reads back current source
// [RQ16] Changeover produces no runt clock pulse
`timescale 1ns/1ps
module mcss_top import mcss_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register bus
  input wire mcss_axi_req_type axi_req,
  output mcss_axi_resp_type axi_resp,
  // Crystal or external clock pin
  input wire logic xtal_clk_pin,
  // CPU standby
  input wire logic halt_exec,
  input wire logic wake_event,
  output logic cpu_halted,
  // Oscillator controls
  output logic crystal_enable,
  output logic crystal_gain_high,
  output logic external_input_enable,
  output logic internal_osc_enable,
  output logic [WAIT_W-1:0] stop_wait_select,
  // Clock gates
  output logic gate_internal,
  output logic gate_highspeed
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] mode, next_mode;
  logic mode_locked, next_mode_locked;
  logic [WAIT_W-1:0] next_wait;
  logic [7:0] run, next_run;
  logic main_source_select, next_select;
  logic main_source_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic pin_s1, pin_s2, pin_s3;
  logic aw_full, next_aw_full, w_full, next_w_full;
  logic [7:0] awaddr_q, next_awaddr;
  logic [31:0] wdata_q, next_wdata;
  logic wstrb0_q, next_wstrb0;
  logic awready, next_awready, wready, next_wready;
  logic bvalid, next_bvalid, arready, next_arready, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic next_halted;
  logic next_xen, next_xgain, next_eien, next_ien;
  logic hs_running, do_write;

  function automatic logic [7:0] wait_flags(input logic [CNT_W-1:0] c);
    logic [7:0] f;
    f = 8'h00;
    for (int i = 0; i < 8; i++) begin
      f[7-i] = (c >> WAIT_EXP[i]) != '0;
    end
    return f;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a inside {OFS_MODE, OFS_WAIT, OFS_RUN, OFS_STAT, OFS_SEL};
  endfunction

  assign hs_running = mode[MODE_PIN_BIT] && !run[RUN_XSTOP_BIT];

  // ----------------------------------------
  // Pin synchroniser and stabilization counter
  // ----------------------------------------
  // Counter saturates so the flags never fall back while the source runs
  always_comb begin
    next_cnt = cnt;
    if (!hs_running) begin
      next_cnt = '0;
    end else if (pin_s2 && !pin_s3 && cnt != '1) begin
      next_cnt = cnt + CNT_W'(1); // [RQ7]
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave and register writes
  // ----------------------------------------
  assign do_write = aw_full && w_full && !bvalid;

  always_comb begin
    next_aw_full = aw_full;
    next_w_full = w_full;
    next_awaddr = awaddr_q;
    next_wdata = wdata_q;
    next_wstrb0 = wstrb0_q;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_arready = arready;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_mode = mode;
    next_mode_locked = mode_locked;
    next_wait = stop_wait_select;
    next_run = run;
    next_select = main_source_select;
    if (axi_req.awvalid && awready) begin
      next_aw_full = 1'b1;
      next_awaddr = axi_req.awaddr[7:0];
    end
    if (axi_req.wvalid && wready) begin
      next_w_full = 1'b1;
      next_wdata = axi_req.wdata;
      next_wstrb0 = axi_req.wstrb[0];
    end
    if (bvalid && axi_req.bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      // Only the low byte lane carries register data
      if (wstrb0_q) begin
        unique case (awaddr_q)
          OFS_MODE: begin
            if (!mode_locked) begin // [RQ4]
              next_mode = wdata_q[7:0] & MODE_MASK;
              next_mode_locked = 1'b1;
            end
          end
          OFS_WAIT: next_wait = wdata_q[WAIT_W-1:0]; // [RQ5]
          OFS_RUN: next_run = wdata_q[7:0] & RUN_MASK; // [RQ6]
          OFS_SEL: next_select = wdata_q[SEL_REQ_BIT]; // [RQ9]
          default: ;
        endcase
      end
    end
    next_awready = !next_aw_full;
    next_wready = !next_w_full;
    if (rvalid && axi_req.rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
    if (axi_req.arvalid && arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = mapped(axi_req.araddr[7:0]) ? RESP_OKAY : RESP_SLVERR;
      unique case (axi_req.araddr[7:0])
        OFS_MODE: next_rdata = {24'h000000, mode};
        OFS_WAIT: next_rdata = {29'h0000000, stop_wait_select};
        OFS_RUN: next_rdata = {24'h000000, run};
        OFS_STAT: next_rdata = {24'h000000, wait_flags(cnt)}; // [RQ7]
        OFS_SEL: next_rdata = 32'(main_source_state) << SEL_STATE_BIT | // [RQ15]
          32'(main_source_select) << SEL_REQ_BIT;
        default: next_rdata = 32'h00000000;
      endcase
    end
    next_arready = !next_rvalid;
  end

  // ----------------------------------------
  // Oscillator controls and halt
  // ----------------------------------------
  // Internal oscillator keeps running while it still drives the gates
  always_comb begin
    next_xen = hs_running && !mode[MODE_EXT_BIT]; // [RQ6]
    next_eien = hs_running && mode[MODE_EXT_BIT];
    next_xgain = mode[MODE_GAIN_BIT];
    next_ien = !run[RUN_ISTOP_BIT] || !main_source_state; // [RQ6]
    next_halted = cpu_halted;
    if (wake_event) begin
      next_halted = 1'b0;
    end else if (halt_exec) begin
      next_halted = 1'b1; // [RQ12]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mode <= MODE_RESET;
      mode_locked <= 1'b0;
      stop_wait_select <= WAIT_RESET;
      run <= RUN_RESET;
      main_source_select <= 1'b0; // [RQ1]
      cnt <= '0;
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb0_q <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
      cpu_halted <= 1'b0;
      crystal_enable <= 1'b0;
      crystal_gain_high <= 1'b0;
      external_input_enable <= 1'b0;
      internal_osc_enable <= 1'b1;
    end else begin
      mode <= next_mode;
      mode_locked <= next_mode_locked;
      stop_wait_select <= next_wait;
      run <= next_run;
      main_source_select <= next_select;
      cnt <= next_cnt;
      pin_s1 <= xtal_clk_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      awaddr_q <= next_awaddr;
      wdata_q <= next_wdata;
      wstrb0_q <= next_wstrb0;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= next_arready;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      cpu_halted <= next_halted;
      crystal_enable <= next_xen;
      crystal_gain_high <= next_xgain;
      external_input_enable <= next_eien;
      internal_osc_enable <= next_ien;
    end
  end

  mcss_glitch_switch u_switch (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .select_hs(main_source_select),
    .ready_int(internal_osc_enable),
    .ready_hs(hs_running),
    .gate_int(gate_internal),
    .gate_hs(gate_highspeed),
    .on_hs(main_source_state)
  );

  assign axi_resp = '{awready: awready, wready: wready, bvalid: bvalid, bresp: bresp,
    arready: arready, rvalid: rvalid, rdata: rdata, rresp: rresp};

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_reset_internal: assert property ($rose(rstn) |-> gate_internal && !gate_highspeed) // [RQ1]
    else $error("not on internal oscillator after reset");
  a_mode_once: assert property (mode_locked |=> $stable(mode)) // [RQ4]
    else $error("mode register changed after first write");
  a_flags_monotone: assert property (hs_running && $past(hs_running) |-> // [RQ7]
    (wait_flags(cnt) & wait_flags($past(cnt))) == wait_flags($past(cnt)))
    else $error("stabilization flag fell while running");
  a_state_follows: assert property ($rose(main_source_select) && hs_running ##1 // [RQ15]
    main_source_select[*4] |-> ##1 main_source_state)
    else $error("state bit missed switch to high-speed");
  a_halt_enter: assert property (halt_exec && !wake_event |=> cpu_halted) // [RQ12]
    else $error("halt not entered");
  a_write_resp: assert property (do_write |=> bvalid)
    else $error("write response missing");
  a_read_resp: assert property (axi_req.arvalid && arready |=> rvalid && !arready)
    else $error("read response missing");
  a_run_hs_osc: assert property (main_source_state |-> crystal_enable || // [RQ9]
    external_input_enable || $past(hs_running, 1))
    else $error("running on stopped high-speed source");
  c_halt_on_hs: cover property (main_source_state && $rose(cpu_halted));
  c_mode_write: cover property ($rose(mode_locked));
  c_flag_last: cover property ((wait_flags(cnt) & 8'h01) != 8'h00);
endmodule

// ==== hw/mcss_pkg.sv ====
// Constants and carrier types of the main clock source switch.
// Assumes a 50 MHz sys_clk and an AXI4-Lite master with 32-bit data.
package mcss_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_WAIT = 8'h04;
  localparam logic [7:0] OFS_RUN = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_SEL = 8'h10;
  // ----------------------------------------
  // Field positions, masks and reset values
  // ----------------------------------------
  localparam int MODE_EXT_BIT = 7;
  localparam int MODE_PIN_BIT = 6;
  localparam int MODE_GAIN_BIT = 0;
  localparam logic [7:0] MODE_MASK = 8'hC1;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam int WAIT_W = 3;
  localparam logic [2:0] WAIT_RESET = 3'h7;
  localparam int RUN_XSTOP_BIT = 7;
  localparam int RUN_ISTOP_BIT = 0;
  localparam logic [7:0] RUN_MASK = 8'h81;
  localparam logic [7:0] RUN_RESET = 8'h80;
  localparam int SEL_REQ_BIT = 4;
  localparam int SEL_STATE_BIT = 5;
  // ----------------------------------------
  // Stabilization counter, switch timing and bus responses
  // ----------------------------------------
  localparam int CNT_W = 19;
  localparam int WAIT_EXP [8] = '{8, 9, 10, 11, 13, 15, 17, 18};
  localparam int SWITCH_HOLD = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } mcss_axi_req_type;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mcss_axi_resp_type;
endpackage

// ==== hw/mcss_glitch_switch.sv ====
// Break-before-make selector of the main clock source.
// Assumes the gates drive latch-based clock gate cells downstream.
`timescale 1ns/1ps
module mcss_glitch_switch import mcss_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Request and source readiness
  input wire logic select_hs,
  input wire logic ready_int,
  input wire logic ready_hs,
  // Gates and state
  output logic gate_int,
  output logic gate_hs,
  output logic on_hs
);
  typedef enum logic [2:0] {
    ON_INT = 3'h0,
    HOLD_TO_HS = 3'h1,
    GAP_TO_HS = 3'h2,
    ON_HS = 3'h3,
    HOLD_TO_INT = 3'h4,
    GAP_TO_INT = 3'h5
  } mcss_sw_state_type;

  mcss_sw_state_type state, next_state;
  logic [1:0] cnt, next_cnt;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Once started a changeover is committed; withdrawing mid-way would cut a period short
  always_comb begin
    next_state = state;
    next_cnt = 2'h0;
    unique case (state)
      ON_INT: begin
        if (select_hs && ready_hs) begin
          next_state = HOLD_TO_HS;
        end
      end
      HOLD_TO_HS: begin // [RQ14]
        next_cnt = cnt + 2'h1;
        if (cnt == 2'(SWITCH_HOLD - 1)) begin
          next_state = GAP_TO_HS;
        end
      end
      GAP_TO_HS: next_state = ON_HS; // [RQ16]
      ON_HS: begin
        if (!select_hs && ready_int) begin
          next_state = HOLD_TO_INT;
        end
      end
      HOLD_TO_INT: begin // [RQ14]
        next_cnt = cnt + 2'h1;
        if (cnt == 2'(SWITCH_HOLD - 1)) begin
          next_state = GAP_TO_INT;
        end
      end
      GAP_TO_INT: next_state = ON_INT; // [RQ16]
      default: next_state = ON_INT;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state <= ON_INT; // [RQ1]
      cnt <= 2'h0;
      gate_int <= 1'b1;
      gate_hs <= 1'b0;
      on_hs <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      gate_int <= next_state inside {ON_INT, HOLD_TO_HS}; // [RQ16]
      gate_hs <= next_state inside {ON_HS, HOLD_TO_INT};
      on_hs <= next_state == ON_HS;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_never_both: assert property (!(gate_int && gate_hs)) // [RQ16]
    else $error("both clock gates open");
  a_gap_after_off: assert property ($fell(gate_int) |-> !gate_hs ##1 gate_hs) // [RQ16]
    else $error("no idle cycle before high-speed gate");
  a_hold_to_hs: assert property (state == ON_INT && select_hs && ready_hs |=> // [RQ14]
    gate_int[*2] ##1 (!gate_int && !gate_hs) ##1 gate_hs)
    else $error("switch to high-speed not after two old cycles");
  a_hold_to_int: assert property (state == ON_HS && !select_hs && ready_int |=> // [RQ14]
    gate_hs[*2] ##1 (!gate_int && !gate_hs) ##1 (gate_int && !on_hs))
    else $error("switch to internal not after two old cycles");
  c_to_hs: cover property ($rose(on_hs));
  c_to_int: cover property ($fell(on_hs) ##[1:20] gate_int);
endmodule

// ==== testbench/mcss_top_test.sv ====
// Self-checking bench of the main clock source switch top.
// Assumes the bench alone drives every input; no partner model.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module mcss_top_test import mcss_pkg::*;;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic sys_clk, rstn, xtal_clk_pin, halt_exec, wake_event;
  mcss_axi_req_type req;
  mcss_axi_resp_type resp;
  logic cpu_halted, crystal_enable, crystal_gain_high, external_input_enable;
  logic internal_osc_enable, gate_internal, gate_highspeed;
  logic [WAIT_W-1:0] stop_wait_select;
  int bad_count = 0, n_tests = 0, cycles = 0;
  logic [1:0] br;
  logic [31:0] rd;
  // 65 us at 50 MHz: upper end of the internal oscillator settling time
  localparam int ACC_WAIT = 3250;

  mcss_top dut (.sys_clk(sys_clk), .rstn(rstn), .axi_req(req), .axi_resp(resp),
    .xtal_clk_pin(xtal_clk_pin), .halt_exec(halt_exec), .wake_event(wake_event),
    .cpu_halted(cpu_halted), .crystal_enable(crystal_enable),
    .crystal_gain_high(crystal_gain_high), .external_input_enable(external_input_enable),
    .internal_osc_enable(internal_osc_enable), .stop_wait_select(stop_wait_select),
    .gate_internal(gate_internal), .gate_highspeed(gate_highspeed));

  always #10 sys_clk = ~sys_clk;
  // 10 MHz crystal, well under the pin limit
  always #50 xtal_clk_pin = ~xtal_clk_pin;
  // Cuts a hang short; the full run needs about 8500 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  // Ready lines stay high; the master never refuses an answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    req.awaddr <= {24'h0, a};
    req.wdata <= d;
    req.wstrb <= s;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (aw && w && resp.bvalid) begin
        br = resp.bresp;
        break;
      end
      if (!aw && resp.awready) begin
        aw = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w && resp.wready) begin
        w = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [1:0] r);
    logic t;
    t = 1'b0;
    req.araddr <= {24'h0, a};
    req.arvalid <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (t && resp.rvalid) begin
        rd = resp.rdata;
        r = resp.rresp;
        break;
      end
      if (!t && resp.arready) begin
        t = 1'b1;
        req.arvalid <= 1'b0;
      end
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [1:0] r;
    rd_reg(a, r);
    `CHK(r, er)
    `CHK(rd, e)
  endtask

  task automatic pulse(input logic h, input logic w, input logic exp_halted);
    halt_exec <= h;
    wake_event <= w;
    @(posedge sys_clk);
    halt_exec <= 1'b0;
    wake_event <= 1'b0;
    @(posedge sys_clk);
    #1 `CHK(cpu_halted, exp_halted)
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    `CHK({gate_internal, gate_highspeed, internal_osc_enable}, 3'b101)
    `CHK({crystal_enable, external_input_enable, cpu_halted}, 3'b000)
    `CHK(stop_wait_select, WAIT_RESET)
    rd_chk(OFS_MODE, 32'h0, RESP_OKAY);
    rd_chk(OFS_WAIT, 32'h7, RESP_OKAY);
    rd_chk(OFS_RUN, 32'h80, RESP_OKAY);
    rd_chk(OFS_SEL, 32'h0, RESP_OKAY);
  endtask

  task automatic t_bus_errors();
    wr(8'h14, 32'hFF, 4'hF);
    `CHK(br, RESP_SLVERR)
    rd_chk(8'h14, 32'h0, RESP_SLVERR);
    wr(OFS_STAT, 32'hFF, 4'hF);
    `CHK(br, RESP_OKAY)
    rd_chk(OFS_STAT, 32'h0, RESP_OKAY);
  endtask

  task automatic t_mode_once();
    // Strobe-less write is not a byte write and must not use up the one write
    wr(OFS_MODE, 32'hC1, 4'h0);
    rd_chk(OFS_MODE, 32'h0, RESP_OKAY);
    // 10 MHz crystal: gain stays clear
    wr(OFS_MODE, 32'h40, 4'h1);
    rd_chk(OFS_MODE, 32'h40, RESP_OKAY);
    wr(OFS_MODE, 32'hC1, 4'h1);
    rd_chk(OFS_MODE, 32'h40, RESP_OKAY);
    `CHK({crystal_gain_high, crystal_enable, external_input_enable}, 3'b000)
    wr(OFS_WAIT, 32'h2, 4'h1);
    rd_chk(OFS_WAIT, 32'h2, RESP_OKAY);
    `CHK(stop_wait_select, 3'h2)
  endtask

  task automatic t_start_poll();
    logic [1:0] r;
    wr(OFS_RUN, 32'h0, 4'h1);
    repeat (2) @(posedge sys_clk);
    #1 `CHK(crystal_enable, 1'b1)
    rd = 32'h0;
    for (int i = 0; i < 4000 && rd[7:5] != 3'b111; i++) begin
      rd_reg(OFS_STAT, r);
    end
    `CHK(rd, 32'hE0)
  endtask

  task automatic t_switch_hs();
    wr(OFS_SEL, 32'h10, 4'h1);
    #1 `CHK({gate_internal, gate_highspeed}, 2'b10)
    repeat (2) @(posedge sys_clk);
    #1 `CHK({gate_internal, gate_highspeed}, 2'b00)
    @(posedge sys_clk);
    #1 `CHK({gate_internal, gate_highspeed}, 2'b01)
    rd_chk(OFS_SEL, 32'h30, RESP_OKAY);
  endtask

  task automatic t_return();
    wr(OFS_RUN, 32'h1, 4'h1);
    repeat (2) @(posedge sys_clk);
    #1 `CHK(internal_osc_enable, 1'b0)
    wr(OFS_RUN, 32'h0, 4'h1);
    repeat (2) @(posedge sys_clk);
    #1 `CHK(internal_osc_enable, 1'b1)
    repeat (ACC_WAIT) @(posedge sys_clk);
    wr(OFS_SEL, 32'h0, 4'h1);
    repeat (4) @(posedge sys_clk);
    #1 `CHK({gate_internal, gate_highspeed}, 2'b10)
    rd_chk(OFS_SEL, 32'h0, RESP_OKAY);
  endtask

  task automatic t_external();
    // Second reset in mid-run unlocks the mode register again
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    #1 `CHK({gate_internal, gate_highspeed, resp.awready, resp.bvalid}, 4'b1010)
    `CHK({internal_osc_enable, stop_wait_select}, 4'hF)
    wr(OFS_MODE, 32'hC1, 4'h1);
    rd_chk(OFS_MODE, 32'hC1, RESP_OKAY);
    `CHK({crystal_gain_high, external_input_enable}, 2'b10)
    // Wait select kept at its reset value; no polling for an external clock
    wr(OFS_RUN, 32'h00, 4'h1);
    wr(OFS_SEL, 32'h10, 4'h1);
    repeat (3) @(posedge sys_clk);
    #1 `CHK({gate_internal, gate_highspeed, external_input_enable, crystal_enable}, 4'b0110)
    rd_chk(OFS_SEL, 32'h30, RESP_OKAY);
  endtask

  // ----------------------------------------
  // Verdict
  // ----------------------------------------
  task automatic report_and_stop();
    if (bad_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    xtal_clk_pin = 1'b0;
    rstn = 1'b0;
    halt_exec = 1'b0;
    wake_event = 1'b0;
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_bus_errors();
    pulse(1'b1, 1'b0, 1'b1);
    pulse(1'b1, 1'b1, 1'b0);
    t_mode_once();
    t_start_poll();
    t_switch_hs();
    pulse(1'b1, 1'b0, 1'b1);
    pulse(1'b0, 1'b1, 1'b0);
    t_return();
    t_external();
    report_and_stop();
  end
endmodule
